// ===== rtl/smpc_top.sv
`timescale 1ns/1ps
// What this block does
// - Sleep only if allow bit set
// - Kind 0 idle,1 noise,2 down,3 standby
// - Halt four cycles beyond start-up
// - Register file and memory stay unchanged
// - Reset wakes, restart at reset vector
// - Idle stops CPU and flash only
// - Idle wakes on every enabled source
// - Idle or noise starts a conversion
// - Noise stops I/O, CPU and flash
// - Noise wake source list applies
// - Power-down stops oscillator and clocks
// - Deep modes wake on level only
// - Standby keeps oscillator, six-cycle wake
// - Standby/down wake source list applies
// - Gate bit freezes peripheral and access
// - Ungating resumes the frozen state
// - Gating acts in active and idle
// - Converter stays on; re-enable extends
// - Comparator off in power-down and standby
// - Brown-out detector stays on always
// - Reference on only when needed
// - Watchdog runs in every mode
module smpc_top (
    input  wire logic                clk,           // System clock
    input  wire logic                rst,           // Async reset, high
    input  wire logic                sleep_exec,    // Sleep instruction pulse
    input  wire logic [7:0]          core_control_reg, // Allow bit and kind field
    input  wire logic [7:0]          peripheral_clock_gate_reg, // Gate bits
    input  wire smpc_pkg::smpc_wake_t wake_in,      // Enabled wake requests
    input  wire logic                reset_event,   // Watchdog/pin/brown-out reset
    input  wire logic                conv_enable,   // Converter enabled
    input  wire logic                comparator_off_bit, // Comparator disabled
    input  wire logic                comp_uses_ref, // Comparator on reference
    input  wire logic                brownout_sleep_fuse, // Detector enabled
    input  wire logic                wdt_enable,    // Watchdog enabled
    output smpc_pkg::smpc_clk_t      clk_en,        // Domain clock enables
    output logic [7:0]               periph_clk_en, // Per-peripheral enables
    output logic [7:0]               periph_acc_en, // Register access enables
    output logic                     core_halt,     // Core held
    output logic                     irq_resume,    // Pulse: service irq then go on
    output logic                     vector_reset,  // Pulse: restart at reset vector
    output logic                     conv_start,    // Pulse: start conversion
    output logic                     conv_extended, // Next conversion extended
    output logic                     comp_enable,   // Comparator powered
    output logic                     ref_enable,    // Voltage reference powered
    output logic                     bod_enable,    // Brown-out detector powered
    output logic                     wdt_run,       // Watchdog running
    output logic                     sleeping       // In a sleep mode
);
    typedef enum logic [1:0] {ST_RUN, ST_SLEEP, ST_START, ST_HALT} smpc_state_t;

    // Input synchronisers for asynchronous wake and reset sources
    logic [10:0] sync1_q;
    logic [10:0] sync2_q;
    logic [10:0] sync1_d;

    always_comb begin
        sync1_d = {reset_event, wake_in};
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync1_q <= 11'h000;
            sync2_q <= 11'h000;
        end else begin
            sync1_q <= sync1_d;
            sync2_q <= sync1_q;
        end
    end

    smpc_pkg::smpc_wake_t wk;
    logic                 rst_ev;
    assign wk     = smpc_pkg::smpc_wake_t'(sync2_q[9:0]);
    assign rst_ev = sync2_q[10];

    // Sleep state machine
    smpc_state_t         st_q, st_d;
    smpc_pkg::smpc_kind_t kind_q, kind_d;
    logic                vec_q, vec_d;
    logic                res_q, res_d;
    logic                start_q, start_d;
    logic                halt_q, halt_d, slp_q, slp_d;
    logic                cnt_load;
    logic [7:0]          cnt_val;
    logic                cnt_busy;
    logic                wake_hit;
    logic                allow;
    smpc_pkg::smpc_kind_t kind_sel;

    assign allow    = core_control_reg[smpc_pkg::SLEEP_ALLOW_POS];
    assign kind_sel = smpc_pkg::smpc_kind_t'(
        core_control_reg[smpc_pkg::SLEEP_KIND_MSB:smpc_pkg::SLEEP_KIND_LSB]);

    // Wake qualification per latched kind
    always_comb begin
        unique case (kind_q)
            smpc_pkg::SMPC_KIND_IDLE: begin
                wake_hit = |wk;
            end
            smpc_pkg::SMPC_KIND_NOISE: begin
                wake_hit = wk.wdt_irq | wk.ext0_level | wk.pin_change | wk.conv_done
                         | wk.nvm_ready | wk.uart_sfd | wk.tws_match;
            end
            smpc_pkg::SMPC_KIND_PWRDOWN,
            smpc_pkg::SMPC_KIND_STANDBY: begin
                wake_hit = wk.wdt_irq | wk.ext0_level | wk.pin_change
                         | wk.uart_sfd | wk.tws_match;
            end
        endcase
    end

    // Standby resumes fast since the oscillator never stopped
    always_comb begin
        st_d     = st_q;
        kind_d   = kind_q;
        vec_d    = 1'b0;
        res_d    = 1'b0;
        start_d  = 1'b0;
        cnt_load = 1'b0;
        cnt_val  = 8'h00;
        unique case (st_q)
            ST_RUN: begin
                if (sleep_exec && allow) begin
                    st_d    = ST_SLEEP;
                    kind_d  = kind_sel;
                    start_d = conv_enable && (kind_sel == smpc_pkg::SMPC_KIND_IDLE
                        || kind_sel == smpc_pkg::SMPC_KIND_NOISE);
                end
            end
            ST_SLEEP: begin
                if (rst_ev) begin
                    st_d  = ST_RUN;
                    vec_d = 1'b1;
                end else if (wake_hit) begin
                    st_d     = ST_START;
                    cnt_load = 1'b1;
                    if (kind_q == smpc_pkg::SMPC_KIND_STANDBY) begin
                        cnt_val = 8'(smpc_pkg::STANDBY_WAKE_CYC - 1);
                    end else begin
                        cnt_val = 8'(smpc_pkg::STARTUP_CYCLES - 1);
                    end
                end
            end
            ST_START: begin
                if (rst_ev) begin
                    st_d  = ST_RUN;
                    vec_d = 1'b1;
                end else if (!cnt_busy) begin
                    st_d     = ST_HALT;
                    cnt_load = 1'b1;
                    cnt_val  = 8'(smpc_pkg::HALT_EXTRA_CYCLES - 1);
                end
            end
            ST_HALT: begin
                if (rst_ev) begin
                    st_d  = ST_RUN;
                    vec_d = 1'b1;
                end else if (!cnt_busy) begin
                    st_d  = ST_RUN;
                    res_d = 1'b1;
                end
            end
        endcase
        halt_d = (st_d != ST_RUN); // Flag from a flop, same timing as the state
        slp_d  = (st_d == ST_SLEEP);
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_q    <= ST_RUN;
            kind_q  <= smpc_pkg::SMPC_KIND_IDLE;
            vec_q   <= 1'b0;
            res_q   <= 1'b0;
            start_q <= 1'b0;
            halt_q  <= 1'b0;
            slp_q   <= 1'b0;
        end else begin
            st_q    <= st_d;
            kind_q  <= kind_d;
            vec_q   <= vec_d;
            res_q   <= res_d;
            start_q <= start_d;
            halt_q  <= halt_d;
            slp_q   <= slp_d;
        end
    end

    smpc_cnt u_cnt (
        .clk   (clk),
        .rst   (rst),
        .load  (cnt_load),
        .value (cnt_val),
        .busy  (cnt_busy)
    );

    // Clock domain and analog enables; registered so outputs are glitch free
    smpc_pkg::smpc_clk_t clk_q, clk_d;
    logic [7:0]          pce_q, pce_d;
    logic                comp_q, comp_d;
    logic                ref_q, ref_d;
    logic                bod_q, bod_d;
    logic                wdt_q, wdt_d;
    logic                conv_on_q, conv_on_d;
    logic                ext_q, ext_d;
    logic                deep;
    logic                asleep;

    assign asleep = (st_q != ST_RUN);
    assign deep   = asleep && (kind_q != smpc_pkg::SMPC_KIND_IDLE);

    // CPU and flash stop for every kind; memories only lose clock, never contents
    always_comb begin
        clk_d = '{osc: 1'b1, cpu: 1'b1, flash: 1'b1, io: 1'b1, conv: 1'b1};
        if (st_q == ST_SLEEP) begin
            clk_d.cpu   = 1'b0;
            clk_d.flash = 1'b0;
            unique case (kind_q)
                smpc_pkg::SMPC_KIND_IDLE: begin
                    clk_d.io = 1'b1;
                end
                smpc_pkg::SMPC_KIND_NOISE: begin
                    clk_d.io = 1'b0;
                end
                smpc_pkg::SMPC_KIND_PWRDOWN: begin
                    clk_d.io   = 1'b0;
                    clk_d.conv = 1'b0;
                    clk_d.osc  = 1'b0;
                end
                smpc_pkg::SMPC_KIND_STANDBY: begin
                    clk_d.io   = 1'b0;
                    clk_d.conv = 1'b0;
                end
            endcase
        end else if (st_q != ST_RUN) begin
            clk_d.cpu   = 1'b0;
            clk_d.flash = 1'b0;
        end
        // Gating only bites when the domain itself runs
        pce_d = ~peripheral_clock_gate_reg;
        if (deep) begin
            pce_d = 8'h00;
        end
        // Comparator and analog supervisors
        comp_d    = !comparator_off_bit && !(deep && kind_q != smpc_pkg::SMPC_KIND_NOISE);
        bod_d     = brownout_sleep_fuse;
        wdt_d     = wdt_enable;
        conv_on_d = conv_enable;
        ext_d     = ext_q;
        if (conv_on_q && !conv_enable) begin
            ext_d = 1'b1;
        end else if (start_q || (conv_enable && !asleep && ext_q && conv_on_q)) begin
            ext_d = ext_q && !start_q;
        end
        // Reference follows its users; a comparator wired to it keeps it up in any sleep
        ref_d = brownout_sleep_fuse || conv_enable
              || (!comparator_off_bit && comp_uses_ref);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            clk_q     <= '{osc: 1'b1, cpu: 1'b1, flash: 1'b1, io: 1'b1, conv: 1'b1};
            pce_q     <= ~smpc_pkg::GATE_RESET;
            comp_q    <= 1'b0;
            ref_q     <= 1'b0;
            bod_q     <= 1'b0;
            wdt_q     <= 1'b0;
            conv_on_q <= 1'b0;
            ext_q     <= 1'b1;
        end else begin
            clk_q     <= clk_d;
            pce_q     <= pce_d;
            comp_q    <= comp_d;
            ref_q     <= ref_d;
            bod_q     <= bod_d;
            wdt_q     <= wdt_d;
            conv_on_q <= conv_on_d;
            ext_q     <= ext_d;
        end
    end

    // Outputs, each straight from a flip-flop
    assign clk_en        = clk_q;
    assign periph_clk_en = pce_q;
    assign periph_acc_en = pce_q;
    assign core_halt     = halt_q;
    assign irq_resume    = res_q;
    assign vector_reset  = vec_q;
    assign conv_start    = start_q;
    assign conv_extended = ext_q;
    assign comp_enable   = comp_q;
    assign ref_enable    = ref_q;
    assign bod_enable    = bod_q;
    assign wdt_run       = wdt_q;
    assign sleeping      = slp_q;

    // Checks
    property p_no_sleep_wo_allow;
        @(posedge clk) disable iff (rst)
        (st_q == ST_RUN && sleep_exec && !allow) |=> st_q == ST_RUN;
    endproperty
    a_no_sleep_wo_allow: assert property (p_no_sleep_wo_allow) else $error("slept without allow");

    property p_halt_four;
        @(posedge clk) disable iff (rst)
        ($rose(st_q == ST_HALT) && !rst_ev) |-> (st_q == ST_HALT && !rst_ev)[*4] ##1 res_q
            or ##[1:4] rst_ev;
    endproperty
    a_halt_four: assert property (p_halt_four) else $error("halt not four cycles");

    property p_reset_vector;
        @(posedge clk) disable iff (rst)
        (st_q == ST_SLEEP && rst_ev) |=> vec_q && st_q == ST_RUN;
    endproperty
    a_reset_vector: assert property (p_reset_vector) else $error("reset did not wake");

    property p_idle_clocks;
        @(posedge clk) disable iff (rst)
        (st_q == ST_SLEEP && kind_q == smpc_pkg::SMPC_KIND_IDLE) |=>
            !clk_q.cpu && clk_q.io && clk_q.osc;
    endproperty
    a_idle_clocks: assert property (p_idle_clocks) else $error("idle clocks wrong");

    property p_conv_start;
        @(posedge clk) disable iff (rst)
        (st_q == ST_RUN && sleep_exec && allow && conv_enable
            && kind_sel == smpc_pkg::SMPC_KIND_NOISE) |=> start_q;
    endproperty
    a_conv_start: assert property (p_conv_start) else $error("no auto conversion");

    property p_pd_osc;
        @(posedge clk) disable iff (rst)
        (st_q == ST_SLEEP && kind_q == smpc_pkg::SMPC_KIND_PWRDOWN) |=> !clk_q.osc;
    endproperty
    a_pd_osc: assert property (p_pd_osc) else $error("oscillator ran in power-down");

    property p_edge_no_wake;
        @(posedge clk) disable iff (rst)
        (st_q == ST_SLEEP && kind_q != smpc_pkg::SMPC_KIND_IDLE && !rst_ev
            && wk == smpc_pkg::smpc_wake_t'(10'h080)) |=> st_q == ST_SLEEP;
    endproperty
    a_edge_no_wake: assert property (p_edge_no_wake) else $error("edge woke deep sleep");
    property p_standby_six;
        @(posedge clk) disable iff (rst)
        (st_q == ST_SLEEP && kind_q == smpc_pkg::SMPC_KIND_STANDBY && wake_hit && !rst_ev)
            |=> (st_q == ST_START && !rst_ev)[*6] ##1 st_q == ST_HALT or ##[0:5] rst_ev;
    endproperty
    a_standby_six: assert property (p_standby_six) else $error("standby wake slow");

    property p_gate;
        @(posedge clk) disable iff (rst)
        (!deep && peripheral_clock_gate_reg[smpc_pkg::GATE_CONV_POS])
            |=> !pce_q[smpc_pkg::GATE_CONV_POS];
    endproperty
    a_gate: assert property (p_gate) else $error("gate bit ignored");

    property p_wdt;
        @(posedge clk) disable iff (rst)
        wdt_enable |=> wdt_q;
    endproperty
    a_wdt: assert property (p_wdt) else $error("watchdog stopped");

    c_idle_wake: cover property (@(posedge clk) disable iff (rst)
        st_q == ST_SLEEP && kind_q == smpc_pkg::SMPC_KIND_IDLE ##1 st_q == ST_START);
    c_resume: cover property (@(posedge clk) disable iff (rst) res_q);
    c_reset_wake: cover property (@(posedge clk) disable iff (rst) vec_q);
    c_standby: cover property (@(posedge clk) disable iff (rst)
        st_q == ST_SLEEP && kind_q == smpc_pkg::SMPC_KIND_STANDBY);
endmodule

// ===== rtl/smpc_pkg.sv
package smpc_pkg;

    // Sleep kind field encoding
    typedef enum logic [1:0] {
        SMPC_KIND_IDLE    = 2'h0,
        SMPC_KIND_NOISE   = 2'h1,
        SMPC_KIND_PWRDOWN = 2'h2,
        SMPC_KIND_STANDBY = 2'h3
    } smpc_kind_t;

    // Core control register field positions
    localparam int unsigned SLEEP_ALLOW_POS = 5;
    localparam int unsigned SLEEP_KIND_LSB  = 3;
    localparam int unsigned SLEEP_KIND_MSB  = 4;

    // Peripheral clock gate register bit positions
    localparam int unsigned GATE_CONV_POS  = 0;
    localparam int unsigned GATE_NPERIPH   = 8;
    localparam logic [7:0]  GATE_RESET     = 8'h00;

    // Resume timing
    localparam int unsigned CLK_PERIOD_NS     = 8;
    localparam int unsigned HALT_EXTRA_CYCLES = 4;
    localparam int unsigned STANDBY_WAKE_CYC  = 6;
    localparam int unsigned STARTUP_NS        = 64;
    localparam int unsigned STARTUP_CYCLES    =
        (STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Wake request bundle
    typedef struct packed {
        logic wdt_irq;      // Watchdog interrupt
        logic ext0_level;   // External irq zero, level mode
        logic ext0_edge;    // External irq zero, edge mode
        logic pin_change;   // Pin change interrupt
        logic conv_done;    // Converter complete
        logic nvm_ready;    // Self-write or nonvolatile ready
        logic uart_sfd;     // Serial start-frame detection
        logic tws_match;    // Two-wire slave address match
        logic timer_ovf;    // Timer overflow
        logic other_io;     // Any other I/O interrupt
    } smpc_wake_t;

    // Clock enables handed to the clock tree
    typedef struct packed {
        logic osc;          // Main oscillator
        logic cpu;          // CPU domain
        logic flash;        // Flash domain
        logic io;           // I/O domain
        logic conv;         // Converter domain
    } smpc_clk_t;

endpackage

// ===== rtl/smpc_cnt.sv
`timescale 1ns/1ps
// Load-and-count-down timer used for resume delays
module smpc_cnt (
    input  wire logic       clk,   // System clock
    input  wire logic       rst,   // Async reset, high
    input  wire logic       load,  // Load pulse
    input  wire logic [7:0] value, // Count to load
    output logic            busy   // High while counting
);
    logic [7:0] cnt_q;
    logic [7:0] cnt_d;

    // Next count; a load wins over counting
    always_comb begin
        cnt_d = cnt_q;
        if (load) begin
            cnt_d = value;
        end else if (cnt_q != 8'h00) begin
            cnt_d = cnt_q - 8'h01;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_q <= 8'h00;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign busy = (cnt_q != 8'h00);
endmodule

// ===== sim/smpc_partner.sv
`timescale 1ns/1ps
// Interrupt sources on the far side of the controller
module smpc_partner (
    input  wire logic            clk,          // System clock
    input  wire logic            rst,          // Async reset, high
    input  wire logic            raise,        // Pulse: assert selected source
    input  wire logic            drop,         // Pulse: withdraw every source
    input  wire logic [3:0]      sel,          // Source index in the bundle
    input  wire logic            irq_resume,   // Core entered the handler
    input  wire logic            vector_reset, // Core restarted
    output smpc_pkg::smpc_wake_t wake_in       // Wake request levels
);
    logic [9:0] req_q;
    logic [9:0] req_d;

    // A level source holds its request until the handler runs, or the wake is lost
    always_comb begin
        req_d = req_q;
        if (raise) begin
            req_d[sel] = 1'b1;
        end
        if (drop || irq_resume || vector_reset) begin
            req_d = 10'h000;
        end
    end

    // Request levels
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            req_q <= 10'h000;
        end else begin
            req_q <= req_d;
        end
    end

    assign wake_in = req_q;
endmodule

// ===== sim/testbench.sv
`timescale 1ns/1ps
// Drives the core side, checks domain gating, wake filtering and resume
module testbench;
    logic                 clk;
    logic                 rst;
    logic                 sleep_exec;
    logic [7:0]           core_control_reg;
    logic [7:0]           peripheral_clock_gate_reg;
    smpc_pkg::smpc_wake_t wake_in;
    logic                 reset_event;
    logic                 conv_enable;
    logic                 comparator_off_bit;
    logic                 comp_uses_ref;
    logic                 brownout_sleep_fuse;
    logic                 wdt_enable;
    smpc_pkg::smpc_clk_t  clk_en;
    logic [7:0]           periph_clk_en;
    logic [7:0]           periph_acc_en;
    logic                 core_halt;
    logic                 irq_resume;
    logic                 vector_reset;
    logic                 conv_start;
    logic                 conv_extended;
    logic                 comp_enable;
    logic                 ref_enable;
    logic                 bod_enable;
    logic                 wdt_run;
    logic                 sleeping;
    logic                 raise;
    logic                 drop;
    logic [3:0]           sel;
    logic                 cs;
    logic                 seen_irq;
    int                   mismatches = 0;
    int                   comparisons = 0;
    int                   cycles = 0;
    int                   lat[4];
    // Per kind: idle, noise, power-down, standby
    logic [4:0] exp_clk[4] = '{5'h13, 5'h11, 5'h00, 5'h10};
    logic [3:0] wsrc[4]    = '{4'h1, 4'h5, 4'h6, 4'h8};
    logic [3:0] rsrc[4]    = '{4'h0, 4'h1, 4'h5, 4'h7};
    // Reference table: bod, conv, comparator off, uses reference, expected
    logic [4:0] rtab[5]    = '{5'h06, 5'h03, 5'h00, 5'h0D, 5'h15};

    smpc_top smpc_top_inst (.clk(clk), .rst(rst), .sleep_exec(sleep_exec),
        .core_control_reg(core_control_reg),
        .peripheral_clock_gate_reg(peripheral_clock_gate_reg), .wake_in(wake_in),
        .reset_event(reset_event), .conv_enable(conv_enable),
        .comparator_off_bit(comparator_off_bit), .comp_uses_ref(comp_uses_ref),
        .brownout_sleep_fuse(brownout_sleep_fuse), .wdt_enable(wdt_enable),
        .clk_en(clk_en), .periph_clk_en(periph_clk_en), .periph_acc_en(periph_acc_en),
        .core_halt(core_halt), .irq_resume(irq_resume), .vector_reset(vector_reset),
        .conv_start(conv_start), .conv_extended(conv_extended), .comp_enable(comp_enable),
        .ref_enable(ref_enable), .bod_enable(bod_enable), .wdt_run(wdt_run),
        .sleeping(sleeping));

    smpc_partner smpc_partner_inst (.clk(clk), .rst(rst), .raise(raise), .drop(drop),
        .sel(sel), .irq_resume(irq_resume), .vector_reset(vector_reset), .wake_in(wake_in));

    // Clock, 8 ns period
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Hang guard, well above the few hundred cycles the sequence needs
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            close_out();
        end
    end

    task automatic close_out();
        if (mismatches == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Inputs always move 1 ns after the edge
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Sleep instruction with allow set; notes whether a conversion was launched
    task automatic enter(input logic [1:0] kind);
        cs = 1'b0;
        core_control_reg = {2'h0, 1'b1, kind, 3'h0};
        sleep_exec = 1'b1;
        step(1);
        sleep_exec = 1'b0;
        repeat (3) begin
            cs = cs | conv_start;
            step(1);
        end
    endtask

    // Raise one source and count cycles until the handler pulse
    task automatic wake_meas(input logic [3:0] src, output int n);
        n = 0;
        raise = 1'b1;
        sel = src;
        step(1);
        raise = 1'b0;
        while (irq_resume !== 1'b1 && n < 100) begin
            step(1);
            n++;
        end
    endtask

    // Main sequence
    initial begin
        rst = 1'b1;
        sleep_exec = 1'b0;
        core_control_reg = 8'h00;
        peripheral_clock_gate_reg = 8'h00;
        reset_event = 1'b0;
        conv_enable = 1'b0;
        comparator_off_bit = 1'b0;
        comp_uses_ref = 1'b1;
        brownout_sleep_fuse = 1'b1;
        wdt_enable = 1'b1;
        raise = 1'b0;
        drop = 1'b0;
        sel = 4'h0;
        step(4);
        rst = 1'b0;
        chk(8'(conv_extended), 8'h01);
        // Sleep instruction with allow clear does nothing
        core_control_reg = 8'h10;
        sleep_exec = 1'b1;
        step(1);
        sleep_exec = 1'b0;
        step(3);
        chk(8'(sleeping), 8'h00);
        chk({3'h0, clk_en}, 8'h1F);
        // Gating in run mode, then release
        peripheral_clock_gate_reg = 8'hA5;
        step(2);
        chk(periph_clk_en, 8'h5A);
        chk(periph_acc_en, 8'h5A);
        peripheral_clock_gate_reg = 8'h00;
        step(2);
        chk(periph_acc_en, 8'hFF);
        // Reference needs, one row at a time
        for (int i = 0; i < 5; i++) begin
            {brownout_sleep_fuse, conv_enable, comparator_off_bit, comp_uses_ref} = rtab[i][4:1];
            step(2);
            chk(8'(ref_enable), 8'(rtab[i][0]));
            chk(8'(comp_enable), {7'h00, ~rtab[i][2]});
            chk(8'(bod_enable), 8'(rtab[i][4]));
        end
        {brownout_sleep_fuse, conv_enable, comparator_off_bit, comp_uses_ref} = 4'hD;
        // Every kind: domains, side effects, a refused source (all but idle), then a wake
        for (int k = 0; k < 4; k++) begin
            peripheral_clock_gate_reg = 8'h0F;
            step(4);
            enter(2'(k));
            chk(8'(sleeping), 8'h01);
            chk({3'h0, clk_en}, {3'h0, exp_clk[k]});
            chk(periph_clk_en, (k == 0) ? 8'hF0 : 8'h00);
            chk(8'(cs), 8'(k < 2));
            chk(8'(comp_enable), 8'(k < 2));
            chk(8'(ref_enable), 8'h01);
            chk(8'(bod_enable), 8'h01);
            chk(8'(wdt_run), 8'h01);
            if (k > 0) begin
                raise = 1'b1;
                sel = rsrc[k];
                step(1);
                raise = 1'b0;
                step(12);
                chk(8'(sleeping), 8'h01);
                drop = 1'b1;
                step(1);
                drop = 1'b0;
            end
            // Kind field rewritten mid-sleep must not change the domains
            core_control_reg = {3'h0, ~2'(k), 3'h0};
            step(2);
            chk({3'h0, clk_en}, {3'h0, exp_clk[k]});
            wake_meas(wsrc[k], lat[k]);
            chk(8'(irq_resume), 8'h01);
            step(1);
            chk(8'(core_halt), 8'h00);
            chk({3'h0, clk_en}, 8'h1F);
        end
        chk(8'(lat[0] >= int'(smpc_pkg::STARTUP_CYCLES + smpc_pkg::HALT_EXTRA_CYCLES)), 8'h01);
        chk(8'(lat[2] >= int'(smpc_pkg::STARTUP_CYCLES + smpc_pkg::HALT_EXTRA_CYCLES)), 8'h01);
        chk(8'(lat[3] < lat[2]), 8'h01);
        chk(8'(conv_extended), 8'h00);
        conv_enable = 1'b0;
        step(2);
        chk(8'(conv_extended), 8'h01);
        // Reset request while powered down restarts from the vector
        enter(smpc_pkg::SMPC_KIND_PWRDOWN);
        reset_event = 1'b1;
        seen_irq = 1'b0;
        for (int i = 0; i < 10 && vector_reset !== 1'b1; i++) begin
            seen_irq = seen_irq | irq_resume;
            step(1);
        end
        chk(8'(vector_reset), 8'h01);
        reset_event = 1'b0;
        step(1);
        chk(8'(seen_irq | irq_resume), 8'h00);
        chk(8'(core_halt), 8'h00);
        close_out();
    end
endmodule
